// ==== shared/isf_params.svh ====
`ifndef ISF_PARAMS_SVH
`define ISF_PARAMS_SVH

// register offsets, byte addresses of 32-bit words
`define ISF_OFS_STATUS 8'h00
`define ISF_OFS_ENABLE 8'h04
`define ISF_OFS_CLEAR 8'h08
`define ISF_OFS_MODE 8'h0c
`define ISF_OFS_TXHOLD 8'h10
`define ISF_OFS_RXDATA 8'h14

// flag positions inside the status word
`define ISF_BIT_NACK 1
`define ISF_BIT_REGISTER_ACCESS_READY_FLAG 2
`define ISF_BIT_RRDY 3
`define ISF_BIT_XRDY 4
`define ISF_FLAG_LSB 1
`define ISF_FLAG_MSB 4

// flag vector index (status bit minus one)
`define ISF_IDX_NACK 0
`define ISF_IDX_REGISTER_ACCESS_READY_FLAG 1
`define ISF_IDX_RRDY 2
`define ISF_IDX_XRDY 3

// flag reset value: transmit-ready is forced high in reset
`define ISF_FLAG_RST 4'h8

// mode control fields
`define ISF_MODE_RUN 0
`define ISF_MODE_CTRL 1
`define ISF_MODE_REPEAT 2
`define ISF_MODE_STOP 3
`define ISF_MODE_RST 4'h0

// serial bit counter: ninth rising edge is the acknowledge slot
`define ISF_ACK_CNT 4'h8
`define ISF_CNT_RST 4'h0

`endif

// ==== shared/isf_pkg.sv ====
package isf_pkg;
    typedef logic [7:0] isf_addr_t;
    typedef logic [31:0] isf_data_t;
    typedef logic [7:0] isf_byte_t;
    typedef logic [3:0] isf_flags_t;

    // serial bus watcher states
    typedef enum logic [0:0] {
        ISF_LNK_IDLE = 1'b0,
        ISF_LNK_DATA = 1'b1
    } isf_link_e;
endpackage

// ==== rtl/isf_status_flags.sv ====
`timescale 1ns/1ps
`include "isf_params.svh"
module isf_status_flags (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register port
    input wire isf_pkg::isf_addr_t addr_in,
    input wire isf_pkg::isf_data_t wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output isf_pkg::isf_data_t rd_data_out,
    // serial bus pins, asynchronous
    input wire logic scl_in,
    input wire logic sda_in,
    // data path events, same clock
    input wire logic tx_load_in,
    input wire logic rx_xfer_in,
    input wire isf_pkg::isf_byte_t rx_shift_in,
    input wire logic addr_sent_in,
    input wire logic start_use_in,
    input wire logic count_zero_in,
    input wire logic word_done_in,
    input wire logic tx_mode_in,
    input wire logic gen_call_in,
    // outputs to data path and processor
    output isf_pkg::isf_byte_t tx_data_out,
    output logic stop_gen_out,
    output logic run_out,
    output logic irq_out
);
    import isf_pkg::*;

    // address match, used by every register decode
    function automatic logic hit(input isf_addr_t a, input isf_addr_t ofs);
        hit = (a == ofs);
    endfunction

    isf_flags_t flags;
    isf_flags_t enable;
    logic [3:0] mode;
    isf_byte_t rx_data;
    logic scl_s1, scl_s2, scl_q;
    logic sda_s1, sda_s2, sda_q;
    isf_link_e link_st, next_link_st;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic ack_slot;

    // register decode
    wire wr_status = wr_in && hit(addr_in, `ISF_OFS_STATUS);
    wire wr_enable = wr_in && hit(addr_in, `ISF_OFS_ENABLE);
    wire wr_clear = wr_in && hit(addr_in, `ISF_OFS_CLEAR);
    wire wr_mode = wr_in && hit(addr_in, `ISF_OFS_MODE);
    wire wr_txhold = wr_in && hit(addr_in, `ISF_OFS_TXHOLD);
    wire rd_rxdata = rd_in && hit(addr_in, `ISF_OFS_RXDATA);
    wire run = mode[`ISF_MODE_RUN];
    wire ctrl = mode[`ISF_MODE_CTRL];
    wire repeat_sel = mode[`ISF_MODE_REPEAT];
    wire stop_req = mode[`ISF_MODE_STOP];
    wire isf_flags_t sw_clr =
        (wr_status || wr_clear) ?
        wr_data_in[`ISF_FLAG_MSB:`ISF_FLAG_LSB] : 4'h0;

    // bus line conditions from the synchronised pins; ack results also use tx_mode_in and gen_call_in
    wire scl_rise = scl_s2 && !scl_q;
    wire start_cond = scl_s2 && scl_q && sda_q && !sda_s2;
    wire stop_cond = scl_s2 && scl_q && !sda_q && sda_s2;
    wire ack_eval = ack_slot && tx_mode_in;
    wire got_nack = ack_eval && (sda_s2 || gen_call_in);
    wire got_ack = ack_eval && !sda_s2 && !gen_call_in;

    // access-ready set sources, controller mode only
    wire register_access_ready_flag_addr = ctrl && addr_sent_in;
    wire register_access_ready_flag_cnt = ctrl && !repeat_sel && !stop_req && count_zero_in;
    wire register_access_ready_flag_rep = ctrl && repeat_sel && word_done_in;
    wire stop_hit = ctrl && !repeat_sel && stop_req && count_zero_in;

    // per-flag hardware set and clear
    wire isf_flags_t hw_set = {
        tx_load_in,
        rx_xfer_in,
        register_access_ready_flag_addr || register_access_ready_flag_cnt || register_access_ready_flag_rep,
        got_nack
    };
    wire isf_flags_t hw_clr = {
        wr_txhold,
        rd_rxdata,
        start_use_in,
        got_ack
    };

    // sticky flags: a set in the clear cycle wins, soft reset wins over all
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            localparam isf_flags_t RST_VAL = `ISF_FLAG_RST;
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    flags[gi] <= RST_VAL[gi];
                end else if (!run) begin
                    flags[gi] <= RST_VAL[gi];
                end else begin
                    flags[gi] <= hw_set[gi] ||
                        (flags[gi] && !hw_clr[gi] && !sw_clr[gi]);
                end
            end
        end
    endgenerate

    // software registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode <= `ISF_MODE_RST;
            enable <= 4'h0;
            tx_data_out <= 8'h00;
        end else begin
            if (wr_mode)
                mode <= wr_data_in[3:0];
            if (wr_enable)
                enable <= wr_data_in[`ISF_FLAG_MSB:`ISF_FLAG_LSB];
            if (wr_txhold)
                tx_data_out <= wr_data_in[7:0];
        end
    end

    // receive data capture; stale contents kept through soft reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            rx_data <= 8'h00;
        else if (rx_xfer_in)
            rx_data <= rx_shift_in;
    end

    // read data, one cycle after the strobe; write-only words read zero
    wire isf_data_t rd_mux =
        hit(addr_in, `ISF_OFS_STATUS) ? {27'h0, flags, 1'b0} :
        hit(addr_in, `ISF_OFS_ENABLE) ? {27'h0, enable, 1'b0} :
        hit(addr_in, `ISF_OFS_MODE) ? {28'h0, mode} :
        hit(addr_in, `ISF_OFS_RXDATA) ? {24'h0, rx_data} : 32'h0;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            rd_data_out <= 32'h0;
        else
            rd_data_out <= rd_in ? rd_mux : 32'h0;
    end

    // stop request pulse toward the bus engine
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            stop_gen_out <= 1'b0;
        else
            stop_gen_out <= run && stop_hit;
    end

    // two-flop synchronisers plus one delay stage for edge finding
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_q <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_q <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_q <= sda_s2;
        end
    end

    // bit counter: a start (or repeated start) restarts the byte framing
    always_comb begin
        next_link_st = link_st;
        next_bit_cnt = bit_cnt;
        ack_slot = 1'b0;
        case (link_st)
            ISF_LNK_IDLE: begin
                if (start_cond) begin
                    next_link_st = ISF_LNK_DATA;
                    next_bit_cnt = `ISF_CNT_RST;
                end
            end
            ISF_LNK_DATA: begin
                if (stop_cond) begin
                    next_link_st = ISF_LNK_IDLE;
                end else if (start_cond) begin
                    next_bit_cnt = `ISF_CNT_RST;
                end else if (scl_rise) begin
                    if (bit_cnt == `ISF_ACK_CNT) begin
                        ack_slot = 1'b1;
                        next_bit_cnt = `ISF_CNT_RST;
                    end else begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                end
            end
            default: begin
                next_link_st = ISF_LNK_IDLE;
            end
        endcase
    end

    // watcher state; forced idle with the bit counter cleared while the module is held in soft reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_st <= ISF_LNK_IDLE;
            bit_cnt <= `ISF_CNT_RST;
        end else if (!run) begin
            link_st <= ISF_LNK_IDLE;
            bit_cnt <= `ISF_CNT_RST;
        end else begin
            link_st <= next_link_st;
            bit_cnt <= next_bit_cnt;
        end
    end

    // interrupt level: any enabled sticky flag
    assign irq_out = |(flags & enable);
    assign run_out = run;

    // checks
    sequence s_tx_write;
        run && wr_txhold && !tx_load_in;
    endsequence
    sequence s_ack_seen;
        run && ack_slot && tx_mode_in;
    endsequence

    AST_XRDY_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_tx_write |=> !flags[`ISF_IDX_XRDY])
        else $error("transmit-ready not cleared by holding write");
    AST_XRDY_SOFTRST: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !run [*2] |-> flags == `ISF_FLAG_RST)
        else $error("flags not at reset value while run bit low");
    AST_RRDY_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run && rx_xfer_in |=> flags[`ISF_IDX_RRDY] && rx_data == $past(rx_shift_in))
        else $error("receive-ready or rx data not updated");
    AST_RRDY_READ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run && rd_rxdata && !rx_xfer_in |=> !flags[`ISF_IDX_RRDY])
        else $error("receive-ready not cleared by data read");
    AST_W1C: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run && wr_status && wr_data_in[`ISF_BIT_REGISTER_ACCESS_READY_FLAG] && !hw_set[`ISF_IDX_REGISTER_ACCESS_READY_FLAG]
        |=> !flags[`ISF_IDX_REGISTER_ACCESS_READY_FLAG])
        else $error("access-ready not cleared by write of one");
    AST_REGISTER_ACCESS_READY_FLAG_ADDR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run && ctrl && addr_sent_in |=> flags[`ISF_IDX_REGISTER_ACCESS_READY_FLAG])
        else $error("access-ready not set after address");
    AST_STOP_GEN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run && stop_hit && !addr_sent_in && !word_done_in &&
        !start_use_in && !sw_clr[`ISF_IDX_REGISTER_ACCESS_READY_FLAG]
        |=> stop_gen_out && flags[`ISF_IDX_REGISTER_ACCESS_READY_FLAG] == $past(flags[`ISF_IDX_REGISTER_ACCESS_READY_FLAG]))
        else $error("stop not requested or access-ready disturbed");
    AST_NACK_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_ack_seen ##0 (sda_s2 || gen_call_in) |=> flags[`ISF_IDX_NACK])
        else $error("no-ack flag not set");
    AST_NACK_ACK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_ack_seen ##0 (!sda_s2 && !gen_call_in) |=> !flags[`ISF_IDX_NACK])
        else $error("no-ack flag not cleared by acknowledge");
    AST_IRQ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run && rx_xfer_in && enable[`ISF_IDX_RRDY] && !wr_enable |=> irq_out)
        else $error("interrupt missing for enabled flag");
    AST_RDATA: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_in && hit(addr_in, `ISF_OFS_STATUS)
        |=> rd_data_out[`ISF_FLAG_MSB:`ISF_FLAG_LSB] == $past(flags))
        else $error("status read data wrong");

    // software clears and a status write of zeros, each without a competing hardware set
    sequence s_xrdy_clr;
        run && sw_clr[`ISF_IDX_XRDY] && !tx_load_in;
    endsequence
    sequence s_rrdy_clr;
        run && sw_clr[`ISF_IDX_RRDY] && !rx_xfer_in;
    endsequence
    sequence s_nack_clr;
        run && sw_clr[`ISF_IDX_NACK] && !got_nack;
    endsequence
    sequence s_quiet_write;
        run && wr_status && sw_clr == 4'h0 && hw_set == 4'h0 &&
            hw_clr == 4'h0;
    endsequence

    AST_XRDY_W1C: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        s_xrdy_clr |=> !flags[`ISF_IDX_XRDY])
        else $error("transmit-ready not cleared by write of one");

    AST_RRDY_W1C: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        s_rrdy_clr |=> !flags[`ISF_IDX_RRDY])
        else $error("receive-ready not cleared by write of one");

    AST_NACK_W1C: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        s_nack_clr |=> !flags[`ISF_IDX_NACK])
        else $error("no-ack flag not cleared by write of one");

    AST_ZERO_WRITE: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        s_quiet_write |=> flags == $past(flags))
        else $error("write of zeros disturbed the flags");

    AST_XRDY_LOAD: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        run && tx_load_in |=> flags[`ISF_IDX_XRDY])
        else $error("transmit-ready not set by shift load");

    AST_REGISTER_ACCESS_READY_FLAG_START: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        run && start_use_in && !hw_set[`ISF_IDX_REGISTER_ACCESS_READY_FLAG]
        |=> !flags[`ISF_IDX_REGISTER_ACCESS_READY_FLAG])
        else $error("access-ready not cleared when settings used");

    AST_REGISTER_ACCESS_READY_FLAG_COUNT: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        run && ctrl && !repeat_sel && !stop_req && count_zero_in
        |=> flags[`ISF_IDX_REGISTER_ACCESS_READY_FLAG])
        else $error("access-ready not set at zero count");

    AST_REGISTER_ACCESS_READY_FLAG_REPEAT: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        run && ctrl && repeat_sel && word_done_in
        |=> flags[`ISF_IDX_REGISTER_ACCESS_READY_FLAG])
        else $error("access-ready not set after repeat word");

    AST_REGISTER_ACCESS_READY_FLAG_TARGET: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        run && !ctrl && !flags[`ISF_IDX_REGISTER_ACCESS_READY_FLAG] |=> !flags[`ISF_IDX_REGISTER_ACCESS_READY_FLAG])
        else $error("access-ready set outside controller mode");

    AST_SOFTRST_CLR: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !run |=> flags == `ISF_FLAG_RST)
        else $error("flags not reset by run bit low");

    AST_STOP_SOFTRST: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !run |=> !stop_gen_out)
        else $error("stop requested while run bit low");

    AST_NACK_TXONLY: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        run && ack_slot && !tx_mode_in && !sw_clr[`ISF_IDX_NACK]
        |=> flags[`ISF_IDX_NACK] == $past(flags[`ISF_IDX_NACK]))
        else $error("no-ack flag changed while receiving");

    AST_TXDATA: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        wr_txhold |=> tx_data_out == $past(wr_data_in[7:0]))
        else $error("holding word not captured");

    AST_RDATA_IDLE: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !rd_in |=> rd_data_out == 32'h0)
        else $error("read data not zero without a read");

    AST_RXDATA_HOLD: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !rx_xfer_in |=> $stable(rx_data))
        else $error("rx data changed without a transfer");

    AST_IRQ_NACK: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        run && got_nack && enable[`ISF_IDX_NACK] && !wr_enable |=> irq_out)
        else $error("interrupt missing for enabled no-ack");
endmodule // isf_status_flags

// ==== sim/isf_bus_model.sv ====
`timescale 1ns/1ps
// far side of the serial bus: a frame with START, 10 clocks and STOP
module isf_bus_model (
    // control from the bench
    input wire logic go_in,
    input wire logic nack_in,
    // serial pins, pulled up while idle
    output logic scl_out,
    output logic sda_out,
    output logic done_out
);
    // clock stands still outside frames, 80 ns period inside
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        done_out = 1'b0;
        forever begin
            @(posedge go_in);
            done_out = 1'b0;
            #43 sda_out = 1'b0;
            for (int i = 0; i < 9; i++) begin
                #40 scl_out = 1'b0;
                // data bits toggle so a stale level never passes
                sda_out = (i == 8) ? nack_in : ~sda_out;
                #40 scl_out = 1'b1;
            end
            #40 scl_out = 1'b0;
            sda_out = 1'b0;
            #40 scl_out = 1'b1;
            #40 sda_out = 1'b1;
            done_out = 1'b1;
        end
    end
endmodule // isf_bus_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`include "isf_params.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
 mismatches++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
    import isf_pkg::*;
    logic clk, rst_n, wr, rd, go, nack, tx_mode, gen_call, scl, sda, done;
    isf_addr_t addr;
    isf_data_t wdata, rdata;
    isf_byte_t rx_shift, tx_data, b;
    logic [5:0] ev;
    logic stop_gen, run, irq;
    logic rd_q = 1'b0;
    isf_data_t exp_v;
    int mismatches = 0, comparisons = 0, seed = 24;
    isf_data_t expq[$];

    isf_status_flags dut_u (.clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
        .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
        .scl_in(scl), .sda_in(sda), .tx_load_in(ev[0]), .rx_xfer_in(ev[1]),
        .rx_shift_in(rx_shift), .addr_sent_in(ev[2]), .start_use_in(ev[3]),
        .count_zero_in(ev[4]), .word_done_in(ev[5]), .tx_mode_in(tx_mode),
        .gen_call_in(gen_call), .tx_data_out(tx_data),
        .stop_gen_out(stop_gen), .run_out(run), .irq_out(irq));
    isf_bus_model bus_u (.go_in(go), .nack_in(nack), .scl_out(scl),
        .sda_out(sda), .done_out(done));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_q) begin
            exp_v = expq.pop_front();
            `CHK("read data", exp_v, rdata)
        end
        rd_q <= rd;
    end

    task automatic wr_reg(isf_addr_t a, isf_data_t d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(isf_addr_t a, isf_data_t e);
        expq.push_back(e);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic pulse(int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 6'h00;
    endtask

    // one serial frame, ack slot level given by n
    task automatic frame(logic n);
        @(posedge clk);
        nack <= n;
        go <= 1'b1;
        // done falls as the model sees go rise, so wait one edge first
        @(posedge clk);
        go <= 1'b0;
        for (int k = 0; k < 300 && !done; k++) begin
            @(posedge clk);
        end
        if (!done) begin
            mismatches++;
        end
        repeat (6) @(posedge clk);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        #200000;
        mismatches++;
        results();
    end

    initial begin
        {wr, rd, go, nack, tx_mode, gen_call} = 6'h00;
        addr = 8'h00; wdata = 32'h0; rx_shift = 8'h00; ev = 6'h00;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // soft reset: only transmit-ready, events ignored
        pulse(1);
        rd_reg(`ISF_OFS_STATUS, 32'h10);
        `CHK("run", 1'b0, run)
        $display("test reset done");
        wr_reg(`ISF_OFS_MODE, 32'h3);
        b = $random(seed);
        wr_reg(`ISF_OFS_TXHOLD, {24'h0, b});
        @(negedge clk);
        `CHK("tx data", b, tx_data)
        rd_reg(`ISF_OFS_STATUS, 32'h00);
        pulse(0);
        wr_reg(`ISF_OFS_STATUS, 32'h0);
        rd_reg(`ISF_OFS_STATUS, 32'h10);
        wr_reg(`ISF_OFS_STATUS, 32'h10);
        rd_reg(`ISF_OFS_STATUS, 32'h00);
        $display("test transmit done");
        b = $random(seed);
        rx_shift <= b;
        wr_reg(`ISF_OFS_ENABLE, 32'h08);
        @(negedge clk);
        `CHK("irq idle", 1'b0, irq)
        pulse(1);
        @(negedge clk);
        `CHK("irq set", 1'b1, irq)
        rd_reg(`ISF_OFS_RXDATA, {24'h0, b});
        rd_reg(`ISF_OFS_STATUS, 32'h00);
        pulse(1);
        wr_reg(`ISF_OFS_CLEAR, 32'h08);
        rd_reg(`ISF_OFS_STATUS, 32'h00);
        $display("test receive done");
        pulse(2);
        rd_reg(`ISF_OFS_STATUS, 32'h04);
        pulse(3);
        rd_reg(`ISF_OFS_STATUS, 32'h00);
        pulse(4);
        rd_reg(`ISF_OFS_STATUS, 32'h04);
        wr_reg(`ISF_OFS_STATUS, 32'h04);
        rd_reg(`ISF_OFS_STATUS, 32'h00);
        wr_reg(`ISF_OFS_MODE, 32'hb);
        pulse(4);
        @(negedge clk);
        `CHK("stop request", 1'b1, stop_gen)
        rd_reg(`ISF_OFS_STATUS, 32'h00);
        wr_reg(`ISF_OFS_MODE, 32'h7);
        pulse(5);
        rd_reg(`ISF_OFS_STATUS, 32'h04);
        wr_reg(`ISF_OFS_STATUS, 32'h04);
        $display("test access ready done");
        tx_mode <= 1'b1;
        frame(1'b1);
        rd_reg(`ISF_OFS_STATUS, 32'h02);
        frame(1'b0);
        rd_reg(`ISF_OFS_STATUS, 32'h00);
        tx_mode <= 1'b0;
        frame(1'b1);
        rd_reg(`ISF_OFS_STATUS, 32'h00);
        tx_mode <= 1'b1;
        gen_call <= 1'b1;
        frame(1'b0);
        rd_reg(`ISF_OFS_STATUS, 32'h02);
        wr_reg(`ISF_OFS_STATUS, 32'h02);
        rd_reg(`ISF_OFS_STATUS, 32'h00);
        frame(1'b1);
        pulse(1);
        pulse(2);
        wr_reg(`ISF_OFS_MODE, 32'h0);
        rd_reg(`ISF_OFS_STATUS, 32'h10);
        `CHK("irq reset", 1'b0, irq)
        $display("test no-ack done");
        repeat (3) @(posedge clk);
        results();
    end
endmodule // tb
